/* shared/calib_pkg.sv */
// Package for the converter correction path and calibration sequencer.
// Assumes a single 100 MHz system clock and an AHB-Lite register slave.
package calib_pkg;

  localparam int NUM_CH = 3;
  localparam int CH_I = 0;
  localparam int CH_V = 1;
  localparam int CH_T = 2;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE      = 8'h00;
  localparam logic [7:0] OFS_FILTER    = 8'h04;
  localparam logic [7:0] OFS_CFG       = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_OFFSET0   = 8'h10;
  localparam logic [7:0] OFS_GAIN0     = 8'h20;
  localparam logic [7:0] OFS_RESULT0   = 8'h30;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h04;

  // Mode codes
  localparam logic [2:0] MODE_IDLE   = 3'h0;
  localparam logic [2:0] MODE_CONT   = 3'h1;
  localparam logic [2:0] MODE_SINGLE = 3'h2;
  localparam logic [2:0] MODE_SOFF   = 3'h4;
  localparam logic [2:0] MODE_SGAIN  = 3'h5;
  localparam logic [2:0] MODE_ZERO   = 3'h6;
  localparam logic [2:0] MODE_FULL   = 3'h7;

  // Filter config fields
  localparam int FLT_SF_LSB  = 0;
  localparam int FLT_SF_W    = 7;
  localparam int FLT_AF_LSB  = 8;
  localparam int FLT_AF_W    = 6;
  localparam int FLT_CHOP    = 15;
  localparam logic [19:0] FLT_RESET = 20'h00007;

  // Config fields
  localparam int CFG_EN_LSB    = 0;
  localparam int CFG_UNIPOLAR  = 3;
  localparam int CFG_AMPSCALE  = 4;
  localparam int CFG_AUX_V     = 5;
  localparam int CFG_GAIN_LSB  = 8;
  localparam int CFG_GAIN_W    = 4;
  localparam int CFG_SCALE_LSB = 12;
  localparam int CFG_SCALE_W   = 4;
  localparam logic [15:0] CFG_RESET = 16'h1307;

  // Status fields
  localparam int ST_READY_LSB = 0;
  localparam int ST_OVER      = 12;
  localparam int ST_UNDER     = 13;
  localparam int ST_BUSY      = 16;

  // Coefficients
  localparam logic [15:0] GAIN_NOM     = 16'h5555;
  localparam logic [23:0] OFS_FACT_DEF = 24'h000000;
  localparam logic [15:0] GN_FACT_DEF  = 16'h5555;
  localparam int          OFS_ALIGN_SH = 5;  // 2^9/2^4

  // Settling periods in output words
  localparam logic [2:0] SETTLE_PLAIN = 3'h3;
  localparam logic [2:0] SETTLE_CHOP  = 3'h2;
  localparam logic [2:0] SETTLE_GAIN_MULT = 3'h2;

  // Modulator: 512 kHz from 100 MHz
  localparam int CLK_HZ = 100_000_000;
  localparam int MOD_HZ = 512_000;
  localparam int MOD_DIV = CLK_HZ / MOD_HZ;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CONV, ST_CAL
  } seq_state_t;

  typedef struct packed {
    logic [31:0] value;
    logic        over;
    logic        under;
  } corr_result_t;

  typedef struct packed {
    logic [2:0]  mode;
    logic [19:0] filter;
    logic [15:0] cfg;
  } ctrl_t;

endpackage : calib_pkg

/* rtl/adc_offset_gain_calibration.sv */
// Offset/gain correction path and calibration sequencer for a three channel converter.
// Assumes decimated samples arrive as strobed signed words, one per channel, at the
// modulator-derived output rate; registers are reached over AHB-Lite.
`timescale 1ns/100ps

module adc_offset_gain_calibration
  import calib_pkg::*;
#(
  parameter logic [23:0] OFS_FACT_I = calib_pkg::OFS_FACT_DEF, // Arbitrary trim value
  parameter logic [23:0] OFS_FACT_V = calib_pkg::OFS_FACT_DEF,
  parameter logic [23:0] OFS_FACT_T = calib_pkg::OFS_FACT_DEF,
  parameter logic [15:0] GN_FACT_I  = calib_pkg::GN_FACT_DEF,  // Arbitrary, gain 8 trim
  parameter logic [15:0] GN_FACT_V  = calib_pkg::GN_FACT_DEF,
  parameter logic [15:0] GN_FACT_T  = calib_pkg::GN_FACT_DEF
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [2:0]  i_sample_valid,
  input  wire logic [95:0] i_sample_data,
  output logic             o_mod_run,
  output logic             o_zero_input,
  output logic             o_ref_input
);
  import calib_pkg::*;

  seq_state_t state_q;
  logic [2:0]  mode_q;
  logic [19:0] filter_q;
  logic [15:0] cfg_q;
  logic [23:0] offset_q [NUM_CH];
  logic [15:0] gain_q   [NUM_CH];
  logic [31:0] result_q [NUM_CH];
  logic [2:0]  ready_q, over_q, under_q;
  logic [2:0]  cal_mode_q;
  logic [3:0]  words_q;
  logic        chop_half_q [NUM_CH];
  logic signed [31:0] chop_acc_q [NUM_CH];
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [7:0]  mod_cnt_q;

  // Bus address phase
  logic        bus_go;
  assign bus_go    = HSEL && HREADY && HTRANS[1];
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  logic        mode_wr;
  logic [2:0]  new_mode;
  assign mode_wr  = wr_pend_q && (wr_addr_q == OFS_MODE);
  assign new_mode = HWDATA[2:0];

  function automatic logic is_cal(input logic [2:0] m);
    is_cal = m[2];
  endfunction : is_cal

  function automatic logic [31:0] ch_addr(input logic [7:0] base, input int ch);
    ch_addr = {24'h000000, base + 8'(ch * 4)};
  endfunction : ch_addr

  // Correction chain for one averaged sample
  function automatic corr_result_t correct(input logic signed [31:0] raw, input int ch,
                                           input logic [23:0] ofs, input logic [15:0] gn,
                                           input logic [15:0] cfg);
    logic signed [47:0] term, ofs_w, diff, prod;
    logic signed [63:0] scaled;
    logic [3:0]         pgain;
    term   = 48'(raw);
    ofs_w  = 48'(signed'(ofs));
    pgain  = cfg[CFG_GAIN_LSB +: CFG_GAIN_W];
    if (ch == CH_I && cfg[CFG_AMPSCALE])
      term = term * 48'(cfg[CFG_SCALE_LSB +: CFG_SCALE_W]);
    if (ch == CH_V && !cfg[CFG_AUX_V])
      term = term / 48'sd24;
    ofs_w = ((ofs_w <<< OFS_ALIGN_SH) * 48'sd4) / 48'sd3;
    if (ch == CH_I)
      ofs_w = ofs_w / 48'(signed'({1'b0, 16'd1 << pgain}));
    diff   = term - ofs_w;
    scaled = (64'(diff) * 64'(signed'({1'b0, gn}))) / 64'(signed'({1'b0, GAIN_NOM}));
    correct.over  = scaled > 64'sh7fffffff;
    correct.under = scaled < -64'sh80000000;
    if (correct.over)
      prod = 48'sh7fffffff;
    else if (correct.under)
      prod = -48'sh80000000;
    else
      prod = scaled[47:0];
    correct.value = cfg[CFG_UNIPOLAR] ? (prod[31:0] ^ 32'h80000000) : prod[31:0];
  endfunction : correct

  // Gain coefficient from a full-scale reading; the most negative code still has a magnitude
  function automatic logic [31:0] cal_gain_coef(input logic signed [31:0] smp);
    logic [32:0] mag;
    mag = (smp < 32'sh0) ? -33'(smp) : 33'(smp);
    if (mag == 33'h0)
      mag = 33'h1;
    cal_gain_coef = 32'((64'(GAIN_NOM) * 64'h40000000) / 64'(mag));
  endfunction : cal_gain_coef

  // Register write capture
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= bus_go && HWRITE;
      wr_addr_q <= HADDR[7:0];
    end
  end

  // Control registers
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      filter_q <= FLT_RESET;
      cfg_q    <= CFG_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == OFS_FILTER) filter_q <= HWDATA[19:0];
      if (wr_addr_q == OFS_CFG)    cfg_q    <= HWDATA[15:0];
    end
  end

  // Coefficients: factory reload on every reset, then software owned
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      offset_q[CH_I] <= OFS_FACT_I;
      offset_q[CH_V] <= OFS_FACT_V;
      offset_q[CH_T] <= OFS_FACT_T;
      gain_q[CH_I]   <= GN_FACT_I;
      gain_q[CH_V]   <= GN_FACT_V;
      gain_q[CH_T]   <= GN_FACT_T;
    end else if (wr_pend_q) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_addr_q == OFS_OFFSET0 + 8'(c * 4)) offset_q[c] <= HWDATA[23:0];
        if (wr_addr_q == OFS_GAIN0 + 8'(c * 4))   gain_q[c]   <= HWDATA[15:0];
      end
    end
  end

  // Output word rate tick derived from filter setting
  logic        word_tick;
  logic [19:0] dec_cnt_q;
  logic [19:0] dec_len;
  logic        mod_tick;
  assign mod_tick = (mod_cnt_q == 8'(MOD_DIV - 1));
  always_comb begin
    dec_len = 20'(64 * (int'(filter_q[FLT_SF_LSB +: FLT_SF_W]) + 1));
    if (filter_q[FLT_CHOP] || filter_q[FLT_AF_LSB +: FLT_AF_W] != 6'h00)
      dec_len = 20'(int'(dec_len) * (3 + int'(filter_q[FLT_AF_LSB +: FLT_AF_W])));
  end
  assign word_tick = mod_tick && (dec_cnt_q >= dec_len - 20'h1);

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N || state_q == ST_IDLE || mode_wr) begin
      mod_cnt_q <= 8'h00;
      dec_cnt_q <= 20'h0;
    end else begin
      mod_cnt_q <= mod_tick ? 8'h00 : mod_cnt_q + 8'h01;
      if (mod_tick)
        dec_cnt_q <= word_tick ? 20'h0 : dec_cnt_q + 20'h1;
    end
  end

  // Chop averaging of decimated samples
  logic [2:0]          avg_valid;
  logic signed [31:0]  avg_data [NUM_CH];
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (filter_q[FLT_CHOP]) begin
        avg_valid[c] = i_sample_valid[c] && chop_half_q[c];
        avg_data[c]  = 32'((33'(chop_acc_q[c]) + 33'(signed'(i_sample_data[c*32 +: 32]))) >>> 1);
      end else begin
        avg_valid[c] = i_sample_valid[c];
        avg_data[c]  = signed'(i_sample_data[c*32 +: 32]);
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!I_RST_N || state_q == ST_IDLE) begin
        chop_half_q[c] <= 1'b0;
        chop_acc_q[c]  <= 32'sh0;
      end else if (i_sample_valid[c]) begin
        chop_half_q[c] <= !chop_half_q[c];
        chop_acc_q[c]  <= signed'(i_sample_data[c*32 +: 32]);
      end
    end
  end

  // Sequencer
  logic [3:0] settle_words;
  always_comb begin
    settle_words = 4'(filter_q[FLT_CHOP] ? SETTLE_CHOP : SETTLE_PLAIN);
    if (cal_mode_q == MODE_SGAIN)
      settle_words = 4'(settle_words * 4'(SETTLE_GAIN_MULT));
  end
  logic cal_done;
  assign cal_done = state_q == ST_CAL && word_tick && (words_q == settle_words - 4'h1);

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      state_q    <= ST_IDLE;
      mode_q     <= MODE_IDLE;
      cal_mode_q <= MODE_IDLE;
      words_q    <= 4'h0;
    end else if (mode_wr) begin
      mode_q  <= new_mode;
      words_q <= 4'h0;
      if (is_cal(new_mode) && new_mode != 3'h3) begin
        state_q    <= ST_CAL;
        cal_mode_q <= new_mode;
      end else if (new_mode == MODE_CONT || new_mode == MODE_SINGLE)
        state_q <= ST_CONV;
      else
        state_q <= ST_IDLE;
    end else if (cal_done) begin
      state_q <= ST_IDLE;
      mode_q  <= MODE_IDLE;
    end else if (state_q == ST_CAL && word_tick) begin
      words_q <= words_q + 4'h1;
    end else if (state_q == ST_CONV && mode_q == MODE_SINGLE && |avg_valid) begin
      state_q <= ST_IDLE;
      mode_q  <= MODE_IDLE;
    end
  end

  // Result registers: conversions and calibration coefficients
  corr_result_t corr [NUM_CH];
  always_comb begin
    for (int c = 0; c < NUM_CH; c++)
      corr[c] = correct(avg_data[c], c, offset_q[c], gain_q[c], cfg_q);
  end

  always_ff @(posedge I_REF_CLK) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!I_RST_N) begin
        result_q[c] <= 32'h00000000;
        ready_q[c]  <= 1'b0;
        over_q[c]   <= 1'b0;
        under_q[c]  <= 1'b0;
      end else begin
        if (state_q == ST_CONV && avg_valid[c] && cfg_q[CFG_EN_LSB + c]) begin
          result_q[c] <= corr[c].value;
          ready_q[c]  <= 1'b1;
          over_q[c]   <= corr[c].over;
          under_q[c]  <= corr[c].under;
        end else if (state_q == ST_CAL && cfg_q[CFG_EN_LSB + c]) begin
          if (avg_valid[c] && !cal_mode_q[0])
            result_q[c] <= 32'(signed'(avg_data[c][31:OFS_ALIGN_SH]));
          else if (avg_valid[c])
            result_q[c] <= cal_gain_coef(avg_data[c]);
          // Follows the word rate, not the strobe, so the final word is never missed
          ready_q[c] <= cal_done;
        end else if (bus_go && !HWRITE && HADDR[7:0] == OFS_RESULT0 + 8'(c * 4))
          ready_q[c] <= 1'b0;
      end
    end
  end

  // Read data
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h00000000;
    if (HADDR[7:0] == OFS_MODE)   rdata_d = {29'h0, mode_q};
    if (HADDR[7:0] == OFS_FILTER) rdata_d = {12'h000, filter_q};
    if (HADDR[7:0] == OFS_CFG)    rdata_d = {16'h0000, cfg_q};
    if (HADDR[7:0] == OFS_STATUS)
      rdata_d = {15'h0, state_q != ST_IDLE, 2'b00, |under_q, |over_q, 9'h0, ready_q};
    for (int c = 0; c < NUM_CH; c++) begin
      if (HADDR[7:0] == OFS_OFFSET0 + 8'(c * 4)) rdata_d = {8'h00, offset_q[c]};
      if (HADDR[7:0] == OFS_GAIN0 + 8'(c * 4))   rdata_d = {16'h0000, gain_q[c]};
      if (HADDR[7:0] == OFS_RESULT0 + 8'(c * 4)) rdata_d = result_q[c];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N)
      HRDATA <= 32'h00000000;
    else if (bus_go && !HWRITE)
      HRDATA <= rdata_d;
  end

  // Front end steering
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      o_mod_run    <= 1'b0;
      o_zero_input <= 1'b0;
      o_ref_input  <= 1'b0;
    end else begin
      o_mod_run    <= state_q != ST_IDLE;
      o_zero_input <= state_q == ST_CAL && cal_mode_q == MODE_SOFF;
      o_ref_input  <= state_q == ST_CAL && cal_mode_q == MODE_SGAIN;
    end
  end

endmodule : adc_offset_gain_calibration

/* tb/adc_offset_gain_calibration_assertions.sv */
// Checker for the bus response and sequencer outputs of the correction block.
// Sees only the top module ports; attached by the bind at the foot.
`timescale 1ns/100ps
module calib_checker
  import calib_pkg::*;
(
  input wire logic        I_REF_CLK,
  input wire logic        I_RST_N,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        o_mod_run,
  input wire logic        o_zero_input,
  input wire logic        o_ref_input
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  logic mw_q;
  logic rd_q;
  wire  ap = HSEL & HREADY & HTRANS[1];
  // Flags mark the data phase of a mode write or of an unmapped read
  always_ff @(posedge I_REF_CLK) begin
    mw_q <= I_RST_N & ap & HWRITE & (HADDR[7:0] == OFS_MODE);
    rd_q <= I_RST_N & ap & !HWRITE & (HADDR[7:0] == 8'h3c);
  end
  property p_okay; HREADYOUT && !HRESP; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready okay");
  property p_unmapped; rd_q |-> HRDATA == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_zero_run; o_zero_input |-> o_mod_run; endproperty
  a_zero_run: assert property (p_zero_run) else $error("zero input while stopped");
  property p_ref_run; o_ref_input |-> o_mod_run; endproperty
  a_ref_run: assert property (p_ref_run) else $error("reference while stopped");
  property p_soff; mw_q && HWDATA[2:0] == MODE_SOFF |-> ##[1:3] o_zero_input; endproperty
  a_soff: assert property (p_soff) else $error("self offset not started");
  property p_sgain; mw_q && HWDATA[2:0] == MODE_SGAIN |-> ##[1:3] o_ref_input; endproperty
  a_sgain: assert property (p_sgain) else $error("self gain not started");
  property p_sys;
    mw_q && HWDATA[2:1] == 2'b11 |-> ##[1:3] (o_mod_run && !o_zero_input && !o_ref_input);
  endproperty
  a_sys: assert property (p_sys) else $error("system calibration not started");
  property p_idle; mw_q && HWDATA[2:0] == MODE_IDLE |-> ##[1:3] !o_mod_run; endproperty
  a_idle: assert property (p_idle) else $error("idle write left converter running");
  // A mode write reaches the run output two edges after its data phase
  property p_stay; !o_mod_run && !mw_q && !$past(mw_q) |=> !o_mod_run; endproperty
  a_stay: assert property (p_stay) else $error("converter restarted by itself");
  c_soff: cover property (mw_q && HWDATA[2:0] == MODE_SOFF);
  c_end: cover property ($fell(o_mod_run));
  c_unmapped: cover property (rd_q);
endmodule : calib_checker

bind adc_offset_gain_calibration calib_checker u_chk (.I_REF_CLK, .I_RST_N, .HSEL, .HADDR,
  .HTRANS, .HWRITE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .o_mod_run,
  .o_zero_input, .o_ref_input);

/* tb/sample_source.sv */
// Stand-in for the decimation filter: one word per channel every PERIOD cycles.
// Assumes the block's run and zero-input outputs; between words the data is inverted.
`timescale 1ns/100ps
module sample_source #(
  parameter int          PERIOD   = 500,
  parameter logic [31:0] ZERO_RAW = 32'h00000a40
) (
  input  wire logic        i_clk,
  input  wire logic        i_mod_run,
  input  wire logic        i_zero_input,
  input  wire logic [95:0] i_level,
  output logic      [2:0]  o_valid,
  output logic      [95:0] o_data
);
  int cnt = 0;
  initial o_valid = 3'h0;
  initial o_data = 96'h0;
  always @(posedge i_clk) begin
    cnt <= (cnt == PERIOD - 1 || !i_mod_run) ? 0 : cnt + 1;
    o_valid <= 3'h0;
    // Stale words must not look valid, so the bus flips while no word stands
    o_data <= ~o_data;
    if (i_mod_run && cnt == PERIOD - 1) begin
      o_valid <= 3'h7;
      o_data <= i_zero_input ? {3{ZERO_RAW}} : i_level;
    end
  end
endmodule : sample_source

/* tb/tb.sv */
// Self-checking bench: AHB-Lite master tasks and one task per scenario.
// Assumes zero wait-state slave and the sample source partner model.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import calib_pkg::*;
  localparam logic [23:0] OFS_I = 24'h000a5a; // Arbitrary factory trim
  localparam logic [15:0] GN_I  = 16'h5560;   // Arbitrary factory trim
  localparam int          WORD  = 64 * MOD_DIV;
  logic clk, rst_n, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, sv;
  logic [95:0] sd, level;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, run, zi, ri;
  int n_mismatch = 0;
  int n_tests = 0;
  adc_offset_gain_calibration #(.OFS_FACT_I(OFS_I), .GN_FACT_I(GN_I))
    u_adc_offset_gain_calibration (.I_REF_CLK(clk), .I_RST_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .i_sample_valid(sv), .i_sample_data(sd), .o_mod_run(run), .o_zero_input(zi),
    .o_ref_input(ri));
  sample_source u_sample_source (.i_clk(clk), .i_mod_run(run), .i_zero_input(zi),
    .i_level(level), .o_valid(sv), .o_data(sd));
  task automatic conclude;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic step;
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 100);
    if (hreadyout !== 1'b1) begin n_mismatch++; conclude(); end
  endtask : step
  // Called just after a rising edge; returns at the edge that ends the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    step();
    htrans <= 2'h0; hwdata <= d;
    step();
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic wait_rdy(output logic [31:0] q);
    int k;
    k = 0;
    do begin rd(OFS_STATUS, q); k++; end while (q[ST_READY_LSB + CH_T] !== 1'b1 && k < 20000);
    if (k == 20000) begin n_mismatch++; conclude(); end
  endtask : wait_rdy
  task automatic t_reset;
    logic [31:0] q;
    rd(OFS_FILTER, q); `CHK(q[19:0], FLT_RESET)
    rd(OFS_CFG, q); `CHK(q[15:0], CFG_RESET)
    rd(OFS_OFFSET0, q); `CHK(q[23:0], OFS_I)
    rd(OFS_GAIN0, q); `CHK(q[15:0], GN_I)
    rd(8'h3c, q); `CHK(q, 32'h0)
    `CHK(run, 1'b0)
  endtask : t_reset
  task automatic t_reload;
    logic [31:0] q;
    wr(OFS_OFFSET0, 32'h00123456);
    wr(OFS_GAIN0, 32'h00004000);
    rd(OFS_OFFSET0, q); `CHK(q[23:0], 24'h123456)
    rd(OFS_GAIN0, q); `CHK(q[15:0], 16'h4000)
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_OFFSET0, q); `CHK(q[23:0], OFS_I)
    rd(OFS_GAIN0, q); `CHK(q[15:0], GN_I)
  endtask : t_reload
  task automatic t_modes;
    for (int i = 4; i < 8; i++) begin
      wr(OFS_MODE, {29'h0, MODE_CONT});
      repeat (3) @(posedge clk);
      `CHK(run, 1'b1)
      wr(OFS_MODE, 32'(i));
      repeat (3) @(posedge clk);
      `CHK(run, 1'b1)
      `CHK(zi, 1'(i == 4))
      `CHK(ri, 1'(i == 5))
      wr(OFS_MODE, {29'h0, MODE_IDLE});
      repeat (3) @(posedge clk);
      `CHK(run, 1'b0)
    end
  endtask : t_modes
  task automatic t_correct;
    logic [31:0] q;
    level <= {32'h00100000, 64'h0};
    wr(OFS_FILTER, 32'h0);
    wr(OFS_OFFSET0 + 8'h08, 32'h00000003);
    wr(OFS_MODE, {29'h0, MODE_CONT});
    wait_rdy(q);
    rd(OFS_RESULT0 + 8'h08, q); `CHK(q, 32'h000fff80)
    level <= {32'h60000000, 64'h0};
    wr(OFS_GAIN0 + 8'h08, 32'h0000aaaa);
    wait_rdy(q);
    rd(OFS_RESULT0 + 8'h08, q);
    wait_rdy(q);
    `CHK(q[ST_OVER], 1'b1)
    rd(OFS_RESULT0 + 8'h08, q); `CHK(q, 32'h7fffffff)
    wr(OFS_MODE, {29'h0, MODE_IDLE});
  endtask : t_correct
  task automatic t_single;
    logic [31:0] q;
    rd(OFS_RESULT0 + 8'h08, q);
    level <= {32'ha0000000, 32'h00180000, 32'h0};
    wr(OFS_MODE, {29'h0, MODE_SINGLE});
    wait_rdy(q);
    `CHK(q[ST_UNDER], 1'b1)
    `CHK(q[ST_OVER], 1'b0)
    rd(OFS_RESULT0 + 8'h08, q); `CHK(q, 32'h80000000)
    rd(OFS_RESULT0 + 8'h04, q); `CHK(q, 32'h00010000)
    repeat (3) @(posedge clk);
    `CHK(run, 1'b0)
    rd(OFS_MODE, q); `CHK(q[2:0], MODE_IDLE)
    rd(OFS_STATUS, q); `CHK(q[ST_BUSY], 1'b0)
  endtask : t_single
  task automatic t_self_offset;
    logic [31:0] q;
    int k;
    wr(OFS_MODE, {29'h0, MODE_SOFF});
    repeat (3) @(posedge clk);
    k = 3;
    while (run !== 1'b0 && k < 60000) begin @(posedge clk); k++; end
    if (k == 60000) begin n_mismatch++; conclude(); end
    `CHK(k > 2 * WORD && k <= 3 * WORD + 50, 1'b1)
    repeat (20) @(posedge clk);
    `CHK(run, 1'b0)
    rd(OFS_STATUS, q); `CHK(q[ST_READY_LSB + CH_I], 1'b1)
    rd(OFS_RESULT0, q); `CHK(q[23:0], 24'h000052)
    rd(OFS_OFFSET0, q); `CHK(q[23:0], OFS_I)
    wr(OFS_OFFSET0, 32'h00000052);
    rd(OFS_OFFSET0, q); `CHK(q[23:0], 24'h000052)
  endtask : t_self_offset
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; level = 96'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_reload();
    t_modes();
    t_correct();
    t_single();
    t_self_offset();
    conclude();
  end
endmodule : tb
